// ### pkg/rxlt_cfg.svh
`ifndef RXLT_CFG_SVH
`define RXLT_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RXLT_OFF_END_SKIP 8'h05
`define RXLT_OFF_LP_POL 8'h06
`define RXLT_OFF_BYPASS 8'h07
`define RXLT_OFF_HS_TIMEOUT 8'h08
`define RXLT_OFF_IRQ_STATUS 8'h09
`define RXLT_OFF_IRQ_MASK 8'h0a
`define RXLT_OFF_SYNC_SNAP 8'h0e
`define RXLT_OFF_LANE_STATUS 8'h0f
`define RXLT_OFF_LANE0_ERR 8'h10
`define RXLT_OFF_LANE1_ERR 8'h11

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RXLT_RST_END_SKIP 8'h3a
`define RXLT_RST_LP_POL 8'h00
`define RXLT_RST_BYPASS 8'h00
`define RXLT_RST_HS_TIMEOUT 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RXLT_SKIP_LSB 1
`define RXLT_SKIP_MSB 6
`define RXLT_POL_CLK_BIT 4
`define RXLT_BYP_INIT_BIT 7
`define RXLT_BYP_CKMISS_BIT 6
`define RXLT_BYP_ULPS_BIT 5
`define RXLT_ST_SYNC_ERR_BIT 6
`define RXLT_ST_ANY_FAULT_BIT 5
`define RXLT_ST_CLK_ACT_BIT 4
`define RXLT_IRQ_LANE0 0
`define RXLT_IRQ_LANE1 1
`define RXLT_IRQ_SYNC 2
`define RXLT_IRQ_BITS 3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RXLT_CLK_PERIOD_NS 8
`define RXLT_MS_NS 1000000
`define RXLT_MS_CYCLES (`RXLT_MS_NS / `RXLT_CLK_PERIOD_NS)

`endif

// ### pkg/rxlt_pkg.sv
package rxlt_pkg;

  typedef logic [7:0] rxlt_byte_t;
  typedef logic [3:0] rxlt_lanes_t;
  typedef logic [1:0] rxlt_pair_t;

  // Bit order matches the lane error register, bit 4 down to bit 0
  typedef struct packed {
    logic end_sync_fault;
    logic start_sequence_bit_fault;
    logic start_sequence_fault;
    logic hs_request_control_fault;
    logic hs_receive_timeout_fault;
  } rxlt_lane_err_t;

  typedef enum logic [0:0] {
    RXLT_SKIP_IDLE = 1'b0,
    RXLT_SKIP_RUN = 1'b1
  } rxlt_skip_state_t;

endpackage : rxlt_pkg

// ### pkg/rxlt_timer_if.sv
`timescale 1ns/10ps
interface rxlt_timer_if;
  logic [1:0] run;
  logic [7:0] limit;
  logic [1:0] expire;

  modport timer (input run, input limit, output expire);
  modport host (output run, output limit, input expire);
endinterface : rxlt_timer_if

// ### verilog/rxlt_hs_timeout.sv
`timescale 1ns/10ps
`include "rxlt_cfg.svh"
module rxlt_hs_timeout #(
  parameter int MS_CYCLES = `RXLT_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  rxlt_timer_if.timer tmr
);
  import rxlt_pkg::*;

  // ----------------------------------------------------------------
  // Free running millisecond tick
  // ----------------------------------------------------------------
  // Tick is not aligned to the start of a burst, hence the one ms slack
  logic [31:0] pre_cnt;
  wire pre_wrap = (pre_cnt == 32'(MS_CYCLES - 1));
  logic tick;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pre_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      pre_cnt <= pre_wrap ? 32'h0000_0000 : pre_cnt + 32'h0000_0001;
      tick <= pre_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Per lane timeout counters
  // ----------------------------------------------------------------
  wire timer_on = (tmr.limit != 8'h00);
  wire [7:0] last_ms = tmr.limit - 8'h01;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      logic [7:0] ms_cnt;
      wire fire = tick && tmr.run[g] && timer_on && (ms_cnt == last_ms);
      assign tmr.expire[g] = fire;
      always_ff @(posedge core_clk) begin
        if (rst || !tmr.run[g]) begin
          ms_cnt <= 8'h00;
        end else if (tick && ms_cnt != tmr.limit) begin
          ms_cnt <= ms_cnt + 8'h01;
        end
      end

      timeout_off_a: assert property (@(posedge core_clk) disable iff (rst)
        (tmr.limit == 8'h00) |-> !tmr.expire[g])
        else $error("timeout fired while disabled");
      timeout_tick_a: assert property (@(posedge core_clk) disable iff (rst)
        tmr.expire[g] |-> tick && ms_cnt == tmr.limit - 8'h01)
        else $error("timeout fired off the programmed tick");
    end
  endgenerate

endmodule : rxlt_hs_timeout

// ### verilog/rxlt_regs.sv
// Behaviour
// - After end of transmission, discard end_skip_count link DDR periods of data.
// - Bypass bit 7 set skips the power-up initialization wait.
// - Bypass bit 6 set skips the missing-clock timing check.
// - Bypass bit 5 set skips ultra-low-power handling on clock lane 0.
// - Bits 4-0 bypass low-power handling on clock lane and data lanes 3..0.
// - Receive timeout counts 1 ms steps; value N fires between N-1 and N ms.
// - Timeout value zero disables the timeout completely.
// - Status bit 6 sets when enabled lanes detect sync at different times.
// - On a sync error, capture per-lane sync status into a snapshot register.
// - Status bit 5 set while any clock or data lane holds an error.
// - Status bit 5 is read-only and clears once lane errors are read.
// - Status bit 4 shows clock lane activity.
// - Status bits 3-0 show activity of each data lane.
// - Lane error bit 4 flags uncorrectable end-of-transmission sync error.
// - Lane error bit 3 flags correctable bit error in start sequence.
// - Lane error bit 2 flags uncorrectable start sequence error.
// - Lane error bit 1 flags control error in high-speed request mode.
// - Lane error bit 0 flags high-speed reception exceeding the timeout.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`include "rxlt_cfg.svh"
module rxlt_regs #(
  parameter int MS_CYCLES = `RXLT_MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire rxlt_pkg::rxlt_byte_t reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output rxlt_pkg::rxlt_byte_t reg_rdata,
  output logic irq,
  input wire logic link_clk,
  input wire logic clk_lane_active,
  input wire rxlt_pkg::rxlt_lanes_t data_lane_active,
  input wire rxlt_pkg::rxlt_lanes_t lane_sync_seen,
  input wire logic lane_eot_seen,
  input wire rxlt_pkg::rxlt_pair_t lane_hs_rx,
  input wire rxlt_pkg::rxlt_pair_t lane_eot_sync_err,
  input wire rxlt_pkg::rxlt_pair_t lane_sot_bit_err,
  input wire rxlt_pkg::rxlt_pair_t lane_sot_sync_err,
  input wire rxlt_pkg::rxlt_pair_t lane_ctrl_err,
  input wire logic clk_lane_fault,
  output logic lane_data_discard,
  output logic [5:0] end_skip_count,
  output logic lp_clock_lane_invert,
  output rxlt_pkg::rxlt_lanes_t lp_data_lane_invert,
  output logic skip_init_wait,
  output logic skip_clock_miss_check,
  output logic skip_clock_ultra_low_power,
  output logic [4:0] skip_low_power_per_lane
);
  import rxlt_pkg::*;

  // ----------------------------------------------------------------
  // Link side synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 22;
  wire [SW-1:0] async_in = {link_clk, clk_lane_active, data_lane_active, lane_sync_seen,
    lane_eot_seen, lane_hs_rx, lane_eot_sync_err, lane_sot_bit_err, lane_sot_sync_err,
    lane_ctrl_err, clk_lane_fault};
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  logic link_prev;
  logic eot_prev;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
      link_prev <= 1'b0;
      eot_prev <= 1'b0;
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
      link_prev <= sync_b[21];
      // End of transmission is judged against the level at the previous link edge
      if (sync_b[21] && !link_prev) eot_prev <= sync_b[11];
    end
  end

  wire link_s = sync_b[21];
  wire clk_act_s = sync_b[20];
  wire [3:0] dl_act_s = sync_b[19:16];
  wire [3:0] sync_seen_s = sync_b[15:12];
  wire eot_s = sync_b[11];
  wire [1:0] hs_rx_s = sync_b[10:9];
  wire [1:0] eot_err_s = sync_b[8:7];
  wire [1:0] sot_bit_s = sync_b[6:5];
  wire [1:0] sot_err_s = sync_b[4:3];
  wire [1:0] ctrl_err_s = sync_b[2:1];
  wire clk_fault_s = sync_b[0];
  // Lane error, sync and end-of-transmission inputs are only trusted at the rising link clock edge
  wire link_edge = link_s && !link_prev;
  wire eot_event = link_edge && eot_s && !eot_prev;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire sel_skip = (reg_addr == `RXLT_OFF_END_SKIP);
  wire sel_pol = (reg_addr == `RXLT_OFF_LP_POL);
  wire sel_byp = (reg_addr == `RXLT_OFF_BYPASS);
  wire sel_tmo = (reg_addr == `RXLT_OFF_HS_TIMEOUT);
  wire sel_ist = (reg_addr == `RXLT_OFF_IRQ_STATUS);
  wire sel_imk = (reg_addr == `RXLT_OFF_IRQ_MASK);
  wire sel_snap = (reg_addr == `RXLT_OFF_SYNC_SNAP);
  wire sel_stat = (reg_addr == `RXLT_OFF_LANE_STATUS);
  wire sel_l0 = (reg_addr == `RXLT_OFF_LANE0_ERR);
  wire sel_l1 = (reg_addr == `RXLT_OFF_LANE1_ERR);
  wire [1:0] lane_rd = {reg_re && sel_l1, reg_re && sel_l0};
  wire stat_rd = reg_re && sel_stat;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  rxlt_byte_t skip_reg;
  rxlt_byte_t pol_reg;
  rxlt_byte_t byp_reg;
  rxlt_byte_t tmo_reg;
  logic [2:0] irq_mask;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      skip_reg <= `RXLT_RST_END_SKIP;
      pol_reg <= `RXLT_RST_LP_POL;
      byp_reg <= `RXLT_RST_BYPASS;
      tmo_reg <= `RXLT_RST_HS_TIMEOUT;
      irq_mask <= 3'h0;
    end else if (reg_we) begin
      if (sel_skip) skip_reg <= reg_wdata & 8'h7e;
      if (sel_pol) pol_reg <= reg_wdata & 8'h1f;
      if (sel_byp) byp_reg <= reg_wdata;
      if (sel_tmo) tmo_reg <= reg_wdata;
      if (sel_imk) irq_mask <= reg_wdata[2:0];
    end
  end

  assign end_skip_count = skip_reg[`RXLT_SKIP_MSB:`RXLT_SKIP_LSB];
  assign lp_clock_lane_invert = pol_reg[`RXLT_POL_CLK_BIT];
  assign lp_data_lane_invert = pol_reg[3:0];
  assign skip_init_wait = byp_reg[`RXLT_BYP_INIT_BIT];
  assign skip_clock_miss_check = byp_reg[`RXLT_BYP_CKMISS_BIT];
  assign skip_clock_ultra_low_power = byp_reg[`RXLT_BYP_ULPS_BIT];
  assign skip_low_power_per_lane = byp_reg[4:0];

  // ----------------------------------------------------------------
  // Trailing data discard after end of transmission
  // ----------------------------------------------------------------
  rxlt_skip_state_t skip_state;
  rxlt_skip_state_t next_skip_state;
  logic [5:0] skip_left;
  wire skip_load = eot_event && (end_skip_count != 6'h00);

  always_comb begin
    case (skip_state)
      RXLT_SKIP_IDLE: next_skip_state = skip_load ? RXLT_SKIP_RUN : RXLT_SKIP_IDLE;
      RXLT_SKIP_RUN: next_skip_state =
        (link_edge && skip_left == 6'h01) ? RXLT_SKIP_IDLE : RXLT_SKIP_RUN;
      default: next_skip_state = RXLT_SKIP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      skip_state <= RXLT_SKIP_IDLE;
      skip_left <= 6'h00;
    end else begin
      skip_state <= next_skip_state;
      if (skip_state == RXLT_SKIP_IDLE && skip_load) begin
        skip_left <= end_skip_count;
      end else if (skip_state == RXLT_SKIP_RUN && link_edge) begin
        skip_left <= skip_left - 6'h01;
      end
    end
  end

  // One DDR period per link clock edge
  assign lane_data_discard = (skip_state == RXLT_SKIP_RUN);

  // ----------------------------------------------------------------
  // High-speed receive timeout
  // ----------------------------------------------------------------
  rxlt_timer_if tmr ();
  assign tmr.run = hs_rx_s;
  assign tmr.limit = tmo_reg;

  rxlt_hs_timeout #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timeout (
    .core_clk(core_clk),
    .rst(rst),
    .tmr(tmr)
  );

  // ----------------------------------------------------------------
  // Per lane error flags, cleared by reading
  // ----------------------------------------------------------------
  rxlt_lane_err_t lane_err [2];
  logic [1:0] lane_new_err;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_err
      rxlt_lane_err_t set_err;
      assign set_err.end_sync_fault = link_edge && eot_err_s[g];
      assign set_err.start_sequence_bit_fault = link_edge && sot_bit_s[g];
      assign set_err.start_sequence_fault = link_edge && sot_err_s[g];
      assign set_err.hs_request_control_fault = link_edge && ctrl_err_s[g];
      assign set_err.hs_receive_timeout_fault = tmr.expire[g];
      assign lane_new_err[g] = |set_err;
      // A new error in the read cycle survives the clear
      always_ff @(posedge core_clk) begin
        if (rst) begin
          lane_err[g] <= '0;
        end else begin
          lane_err[g] <= (lane_rd[g] ? rxlt_lane_err_t'(5'h00) : lane_err[g]) | set_err;
        end
      end

      rd_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        lane_rd[g] && !lane_new_err[g] |=> lane_err[g] == 5'h00)
        else $error("lane error flags not cleared by read");
      err_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        lane_err[g] != 5'h00 && !lane_rd[g] |=> (lane_err[g] & $past(lane_err[g]))
          == $past(lane_err[g]))
        else $error("lane error flag dropped without a read");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Lane sync check and snapshot
  // ----------------------------------------------------------------
  wire [3:0] sync_enabled = sync_seen_s & dl_act_s;
  wire sync_mismatch = link_edge && (sync_enabled != 4'h0) && (sync_enabled != dl_act_s);
  logic sync_err;
  logic [3:0] sync_snap;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_err <= 1'b0;
      sync_snap <= 4'h0;
    end else begin
      sync_err <= (sync_err && !stat_rd) || sync_mismatch;
      if (sync_mismatch) sync_snap <= sync_seen_s;
    end
  end

  // Clock lane errors live in their own register outside this block
  wire any_lane_fault = (|lane_err[0]) || (|lane_err[1]) || clk_fault_s;
  wire [7:0] status_word = {1'b0, sync_err, any_lane_fault, clk_act_s, dl_act_s};

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [2:0] irq_status;
  wire [2:0] irq_set = {sync_mismatch, lane_new_err};
  wire [2:0] irq_clr = (reg_we && sel_ist) ? reg_wdata[2:0] : 3'h0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  wire [7:0] rd_mux =
    sel_skip ? skip_reg :
    sel_pol ? pol_reg :
    sel_byp ? byp_reg :
    sel_tmo ? tmo_reg :
    sel_ist ? {5'h00, irq_status} :
    sel_imk ? {5'h00, irq_mask} :
    sel_snap ? {4'h0, sync_snap} :
    sel_stat ? status_word :
    sel_l0 ? {3'h0, lane_err[0]} :
    sel_l1 ? {3'h0, lane_err[1]} : 8'h00;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_re ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  skip_start_a: assert property (@(posedge core_clk) disable iff (rst)
    skip_load && !lane_data_discard |=> lane_data_discard && skip_left == $past(end_skip_count))
    else $error("discard did not start after end of transmission");
  init_bypass_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_we && sel_byp |=> skip_init_wait == $past(reg_wdata[7]))
    else $error("init wait bypass not taken from the write");
  ckmiss_bypass_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_we && sel_byp |=> skip_clock_miss_check == $past(reg_wdata[6]))
    else $error("clock miss bypass not taken from the write");
  ulps_bypass_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_we && sel_byp |=> skip_clock_ultra_low_power == $past(reg_wdata[5]))
    else $error("clock lane low power bypass not taken");
  lp_bypass_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_we && sel_byp |=> skip_low_power_per_lane == $past(reg_wdata[4:0]))
    else $error("per lane low power bypass not taken");
  sync_err_a: assert property (@(posedge core_clk) disable iff (rst)
    sync_mismatch |=> sync_err ##1 (sync_err || $past(stat_rd)))
    else $error("lane sync error not flagged");
  sync_snap_a: assert property (@(posedge core_clk) disable iff (rst)
    sync_mismatch |=> sync_snap == $past(sync_seen_s))
    else $error("sync snapshot not captured");
  any_fault_a: assert property (@(posedge core_clk) disable iff (rst)
    lane_err[0] != 5'h00 || lane_err[1] != 5'h00 |-> status_word[5])
    else $error("summary fault flag missing");
  fault_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    lane_rd != 2'h0 ##1 !clk_fault_s && lane_err[0] == 5'h00 && lane_err[1] == 5'h00
      |-> !status_word[5])
    else $error("summary fault flag stuck after read");
  lane_active_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_re && sel_stat |=> reg_rdata[4] == $past(clk_act_s)
      && reg_rdata[3:0] == $past(dl_act_s))
    else $error("lane activity misreported");

endmodule : rxlt_regs

// ### sim/rxlt_lane_model.sv
`timescale 1ns/10ps
module rxlt_lane_model
  import rxlt_pkg::*;
(
  input logic frame_start,
  input int frame_len,
  input rxlt_pkg::rxlt_byte_t frame_err,
  input rxlt_pkg::rxlt_lanes_t frame_sync,
  input logic frame_eot,
  output logic link_clk,
  output rxlt_pkg::rxlt_lanes_t lane_sync_seen,
  output logic lane_eot_seen,
  output rxlt_pkg::rxlt_pair_t lane_eot_sync_err,
  output rxlt_pkg::rxlt_pair_t lane_sot_bit_err,
  output rxlt_pkg::rxlt_pair_t lane_sot_sync_err,
  output rxlt_pkg::rxlt_pair_t lane_ctrl_err
);
  import rxlt_pkg::*;
  logic [7:0] err_v;
  assign lane_ctrl_err = err_v[1:0];
  assign lane_sot_sync_err = err_v[3:2];
  assign lane_sot_bit_err = err_v[5:4];
  assign lane_eot_sync_err = err_v[7:6];
  initial begin
    link_clk = 1'b0;
    err_v = 8'h00;
    lane_sync_seen = 4'h0;
    lane_eot_seen = 1'b0;
  end
  // ----------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------
  // Link clock only toggles inside a frame, idle low between frames
  // Levels hold for the whole frame, then drop back to idle
  always @(posedge frame_start) begin
    err_v = frame_err;
    lane_sync_seen = frame_sync;
    lane_eot_seen = frame_eot;
    #3;
    repeat (frame_len) begin
      #32 link_clk = 1'b1;
      #32 link_clk = 1'b0;
    end
    err_v = 8'h00;
    lane_sync_seen = 4'h0;
    lane_eot_seen = 1'b0;
  end
endmodule : rxlt_lane_model

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
  import rxlt_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  rxlt_byte_t reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic clk_lane_fault = 1'b0;
  rxlt_byte_t reg_rdata;
  logic irq, link_clk, lane_eot_seen, lane_data_discard;
  logic clk_lane_active = 1'b0;
  rxlt_lanes_t data_lane_active = 4'h0;
  rxlt_pair_t lane_hs_rx = 2'b00;
  rxlt_lanes_t lane_sync_seen, lp_data_lane_invert;
  rxlt_pair_t lane_eot_sync_err, lane_sot_bit_err, lane_sot_sync_err, lane_ctrl_err;
  logic frame_start = 1'b0;
  logic frame_eot = 1'b0;
  int frame_len = 0;
  rxlt_byte_t frame_err = 8'h00;
  rxlt_lanes_t frame_sync = 4'h0;
  logic [5:0] end_skip_count;
  logic [4:0] skip_low_power_per_lane;
  logic lp_clock_lane_invert, skip_init_wait, skip_clock_miss_check, skip_clock_ultra_low_power;
  logic [7:0] skip_edges = 8'h00;
  int fails = 0;
  int total_checks = 0;
  logic [7:0] rst_a [11] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0e, 8'h0f,
    8'h10, 8'h11, 8'h20};
  logic [7:0] rst_v [11] = '{8'h3a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  logic [7:0] byp [2] = '{8'ha5, 8'h5a};

  always #4 core_clk = ~core_clk;
  always @(posedge link_clk) if (lane_data_discard === 1'b1) skip_edges++;

  rxlt_regs #(.MS_CYCLES(50)) dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .irq(irq), .link_clk(link_clk), .clk_lane_active(clk_lane_active),
    .data_lane_active(data_lane_active), .lane_sync_seen(lane_sync_seen),
    .lane_eot_seen(lane_eot_seen), .lane_hs_rx(lane_hs_rx),
    .lane_eot_sync_err(lane_eot_sync_err), .lane_sot_bit_err(lane_sot_bit_err),
    .lane_sot_sync_err(lane_sot_sync_err), .lane_ctrl_err(lane_ctrl_err),
    .clk_lane_fault(clk_lane_fault), .lane_data_discard(lane_data_discard),
    .end_skip_count(end_skip_count), .lp_clock_lane_invert(lp_clock_lane_invert),
    .lp_data_lane_invert(lp_data_lane_invert), .skip_init_wait(skip_init_wait),
    .skip_clock_miss_check(skip_clock_miss_check),
    .skip_clock_ultra_low_power(skip_clock_ultra_low_power),
    .skip_low_power_per_lane(skip_low_power_per_lane));

  rxlt_lane_model lane_u (.frame_start(frame_start), .frame_len(frame_len),
    .frame_err(frame_err), .frame_sync(frame_sync), .frame_eot(frame_eot),
    .link_clk(link_clk), .lane_sync_seen(lane_sync_seen), .lane_eot_seen(lane_eot_seen),
    .lane_eot_sync_err(lane_eot_sync_err), .lane_sot_bit_err(lane_sot_bit_err),
    .lane_sot_sync_err(lane_sot_sync_err), .lane_ctrl_err(lane_ctrl_err));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Strobe drops on the taking edge; the extra edge keeps one assignment per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  // Read data stand only in the cycle after the strobe is taken
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), reg_rdata, exp);
    @(posedge core_clk);
  endtask : rdc
  // One link frame of n clock periods; returns after the model has gone idle
  task automatic frame(input int n, input rxlt_byte_t e, input rxlt_lanes_t s, input logic eot);
    frame_len <= n;
    frame_err <= e;
    frame_sync <= s;
    frame_eot <= eot;
    frame_start <= 1'b1;
    @(posedge core_clk);
    frame_start <= 1'b0;
    repeat (n * 8) @(posedge core_clk);
  endtask : frame
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #300000;
    fails++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(5);
    rst <= 1'b0;
    cyc(1);
    chk("skip port", {2'h0, end_skip_count}, 8'h1d);
    foreach (rst_a[i]) rdc(rst_a[i], rst_v[i]);
    wr(8'h05, 8'hff);
    chk("skip port", {2'h0, end_skip_count}, 8'h3f);
    rdc(8'h05, 8'h7e);
    wr(8'h06, 8'hff);
    chk("polarity", {3'h0, lp_clock_lane_invert, lp_data_lane_invert}, 8'h1f);
    rdc(8'h06, 8'h1f);
    foreach (byp[i]) begin
      wr(8'h07, byp[i]);
      chk("bypass", {skip_init_wait, skip_clock_miss_check, skip_clock_ultra_low_power,
        skip_low_power_per_lane}, byp[i]);
      rdc(8'h07, byp[i]);
    end
    wr(8'h08, 8'hff);
    rdc(8'h08, 8'hff);
    clk_lane_active <= 1'b1;
    data_lane_active <= 4'h5;
    cyc(6);
    rdc(8'h0f, 8'h15);
    data_lane_active <= 4'h3;
    cyc(6);
    rdc(8'h0f, 8'h13);
    frame(1, 8'h00, 4'hf, 1'b0);
    cyc(6);
    rdc(8'h0f, 8'h13);
    frame(1, 8'h00, 4'h1, 1'b0);
    cyc(6);
    rdc(8'h0e, 8'h01);
    rdc(8'h0f, 8'h53);
    rdc(8'h0f, 8'h13);
    for (int l = 0; l < 2; l++) begin
      for (int k = 0; k < 4; k++) begin
        frame(1, 8'(8'h01 << (k * 2 + l)), 4'h0, 1'b0);
        cyc(6);
        rdc(8'h0f, 8'h33);
        rdc(8'(8'h10 + l), 8'(8'h02 << k));
        rdc(8'(8'h10 + l), 8'h00);
        rdc(8'h0f, 8'h13);
      end
    end
    clk_lane_fault <= 1'b1;
    cyc(6);
    rdc(8'h0f, 8'h33);
    clk_lane_fault <= 1'b0;
    // Free-running tick: second tick lands 50 to 100 cycles after the start
    wr(8'h08, 8'h02);
    lane_hs_rx <= 2'b01;
    cyc(44);
    rdc(8'h10, 8'h00);
    cyc(60);
    rdc(8'h10, 8'h01);
    lane_hs_rx <= 2'b00;
    wr(8'h08, 8'h00);
    lane_hs_rx <= 2'b11;
    cyc(250);
    rdc(8'h10, 8'h00);
    rdc(8'h11, 8'h00);
    lane_hs_rx <= 2'b00;
    wr(8'h09, 8'h07);
    wr(8'h0a, 8'h01);
    rdc(8'h0a, 8'h01);
    frame(1, 8'h02, 4'h0, 1'b0);
    cyc(6);
    chk("irq masked", {7'h0, irq}, 8'h00);
    rdc(8'h09, 8'h02);
    frame(1, 8'h01, 4'h0, 1'b0);
    cyc(6);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(8'h09, 8'h03);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    rdc(8'h09, 8'h00);
    rdc(8'h10, 8'h02);
    rdc(8'h11, 8'h02);
    wr(8'h05, 8'h06);
    chk("skip port", {2'h0, end_skip_count}, 8'h03);
    skip_edges = 8'h00;
    frame(6, 8'h00, 4'h0, 1'b1);
    cyc(4);
    chk("discard edges", skip_edges, 8'h03);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    rdc(8'h05, 8'h3a);
    rdc(8'h07, 8'h00);
    report_and_stop();
  end
endmodule : tb
